// ---- design/ptl_pkg.sv ----
// Constants, register map and types of the protection pickup/trip block
package ptl_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES_DFLT = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int TICK_W = 17;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VAL_W = 16;
  localparam int BLOCK_W = 4;
  localparam int NUM_BP = 8;
  localparam int IDX_W = 3;
  localparam int UTAB_N = 32;

  // ==========================================================
  // Register word addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PICKUP = 8'h01;
  localparam logic [7:0] REG_DROPOUT = 8'h02;
  localparam logic [7:0] REG_PU_DLY = 8'h03;
  localparam logic [7:0] REG_DO_DLY = 8'h04;
  localparam logic [7:0] REG_TRIP_DLY = 8'h05;
  localparam logic [7:0] REG_COEF = 8'h06;
  localparam logic [7:0] REG_STATUS = 8'h07;
  localparam logic [7:0] REG_ACCUM = 8'h08;
  localparam logic [7:0] REG_UTAB_BASE = 8'h20;
  localparam logic [2:0] UTAB_SEL_MSB = 3'h1;

  // CTRL fields
  localparam int CTRL_INV_BIT = 0;
  localparam int CTRL_CURVE_LSB = 1;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_PICKUP = 16'h0400;
  localparam logic [7:0] RST_DROPOUT = 8'h5f;
  localparam logic [15:0] RST_PU_DLY = 16'h0005;
  localparam logic [15:0] RST_DO_DLY = 16'h0000;
  localparam logic [15:0] RST_TRIP_DLY = 16'h0064;
  localparam logic [15:0] RST_COEF = 16'h0064;

  // ==========================================================
  // Ratio scaling: ratios and percentages as integers
  localparam logic [23:0] RATIO_SCALE = 24'h00000a;
  localparam logic [23:0] PCT_SCALE = 24'h000064;
  // Breakpoints of I/Ip times ten: 1.1 .. 20
  localparam logic [7:0] BREAK_X10 [0:NUM_BP-1] = '{
    8'h0b, 8'h0f, 8'h14, 8'h1e, 8'h32, 8'h50, 8'h78, 8'hc8};
  // Trip limit per hundredth of k: 10 ms per 0.01 times rate scale 4096
  localparam logic [31:0] INV_LIMIT_SCALE = 32'h0000a000;

  // Tick increments 4096/T(M) with T in seconds at k = 1
  localparam logic [15:0] STD_RATE [0:63] = '{
    // IEC normal
    16'h0038, 16'h00ee, 16'h0198, 16'h028a,
    16'h03bd, 16'h04da, 16'h05d3, 16'h070f,
    // IEC very
    16'h001e, 16'h0098, 16'h012f, 16'h025f,
    16'h04be, 16'h084c, 16'h0d09, 16'h1685,
    // IEC extremely
    16'h000b, 16'h0040, 16'h009a, 16'h019a,
    16'h04cd, 16'h0c9a, 16'h1c9a, 16'h4fcd,
    // IEC long time
    16'h0003, 16'h0011, 16'h0022, 16'h0044,
    16'h0089, 16'h00ef, 16'h0177, 16'h0289,
    // IEEE moderately
    16'h0097, 16'h027c, 16'h0435, 16'h0694,
    16'h097b, 16'h0c0f, 16'h0e39, 16'h10e1,
    // IEEE very
    16'h002c, 16'h00fd, 16'h0247, 16'h0570,
    16'h0c3b, 16'h13f3, 16'h197a, 16'h1da1,
    // IEEE extremely
    16'h001e, 16'h00b5, 16'h01ae, 16'h0463,
    16'h0c56, 16'h1c1b, 16'h322c, 16'h5329,
    // Electromechanical emulation
    16'h01fe, 16'h02e8, 16'h0389, 16'h042a,
    16'h04ab, 16'h04f4, 16'h0520, 16'h053c};

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    CRV_IEC_NORMAL = 4'b0000,
    CRV_IEC_VERY = 4'b0001,
    CRV_IEC_EXTREME = 4'b0010,
    CRV_IEC_LONG = 4'b0011,
    CRV_IEEE_MODERATE = 4'b0100,
    CRV_IEEE_VERY = 4'b0101,
    CRV_IEEE_EXTREME = 4'b0110,
    CRV_ELECTROMECHANICAL_EMULATION = 4'b0111,
    CRV_USER1 = 4'b1000,
    CRV_USER2 = 4'b1001,
    CRV_USER3 = 4'b1010,
    CRV_USER4 = 4'b1011
  } ptl_curve_type;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CONFIRM = 2'b01,
    PH_PICKUP = 2'b10,
    PH_DROP = 2'b11
  } ptl_phase_type;

endpackage

// ---- design/ptl_pickup_trip.sv ----
// Protection pickup, drop-out, blocking and trip decision logic
// ==========================================================
// Overview of operation
// - Fault declared when quantity exceeds pickup threshold.
// - Fault ends only below drop-out ratio times pickup.
// - Pickup after fault persists full pickup delay, no block.
// - Fault cleared before trip: pickup holds through drop-out delay.
// - Fault cleared after trip: pickup drops at once.
// - Short dip within drop-out delay keeps the trip timer.
// - Any active block input blocks the function.
// - While blocked pickup is low, pickup-blocked is high.
// - Pickup low clears the trip timer.
// - After block release a present fault restarts pickup sequence.
// - Trip needs fault, pickup, elapsed delay, no block.
// - Trip drops with pickup or any block.
// - Inverse-time ratio clamped to 1.1 through 20.
// - Trip delay is the minimum operate time in inverse mode.
// - Inverse-time integration starts once pickup value reached; the code starts it only in the pickup phase, after the pickup delay.
// - Curve-weighted fractions accumulate; trip at the limit.
// - Curve select: four IEC, three IEEE, emulation, four user.
// - Coefficient k scales the inverse delay linearly.
// - IEC curves k*beta/(M^alpha-1) with the tabled pairs.
// - IEEE curves k*(K/(M^alpha-1)+beta) with tabled values.
// - Emulation curve k/(0.339-0.236/M).
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps

module ptl_pickup_trip #(
  parameter int TICK_CYCLES = ptl_pkg::TICK_CYCLES_DFLT
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ptl_pkg::VAL_W-1:0] quantity,
  input wire logic [ptl_pkg::BLOCK_W-1:0] block_in,
  input wire logic [ptl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ptl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ptl_pkg::DATA_W-1:0] reg_rdata,
  output logic pickup,
  output logic trip,
  output logic pickup_blocked
);
  import ptl_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    ptl_phase_type phase;
    logic fault;
    logic trip;
    logic blocked;
    logic tick;
    logic [TICK_W-1:0] tick_cnt;
    logic [15:0] pu_cnt;
    logic [15:0] do_cnt;
    logic [15:0] trip_cnt;
    logic [31:0] acc;
    logic inv_en;
    ptl_curve_type curve;
    logic [15:0] pickup_val;
    logic [7:0] dropout;
    logic [15:0] pu_dly;
    logic [15:0] do_dly;
    logic [15:0] trip_dly;
    logic [15:0] coef;
    logic [UTAB_N-1:0][15:0] utab;
    logic [31:0] rdata;
  } ptl_state_type;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  // Trip counter stops here instead of wrapping back to zero
  localparam logic [15:0] TRIP_CNT_MAX = 16'hffff;

  ptl_state_type s_q;
  ptl_state_type s_d;

  // ==========================================================
  // Ratio breakpoints
  // Ratio is stepped down to the nearest breakpoint, never
  // interpolated: a fault between two breakpoints trips a bit
  // later than the ideal curve, which errs towards selectivity.
  // Above the top breakpoint the rate stays flat, which gives
  // the clamp at twenty times pickup without a divider.
  logic [NUM_BP-1:0] above_bp;
  logic [23:0] q_x10;
  assign q_x10 = 24'(quantity) * RATIO_SCALE;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BP; gi++) begin : g_bp
      assign above_bp[gi] =
        q_x10 >= 24'(s_q.pickup_val) * 24'(BREAK_X10[gi]);
    end
  endgenerate

  logic [IDX_W-1:0] bp_idx;
  logic [15:0] rate;
  logic [31:0] limit;
  logic [32:0] acc_sum;
  logic inv_done;
  logic dly_done;
  logic blocked_now;
  logic above_pu;
  logic below_do;

  always_comb begin
    // below 1.1 uses entry 0, beyond 20 uses the last
    bp_idx = '0;
    for (int i = 1; i < NUM_BP; i++) begin
      if (above_bp[i]) begin
        bp_idx = IDX_W'(i);
      end
    end
  end

  // ==========================================================
  // Curve selection
  always_comb begin
    if (s_q.curve[3]) begin
      rate = s_q.utab[{s_q.curve[1:0], bp_idx}];
    end else begin
      rate = STD_RATE[{s_q.curve[2:0], bp_idx}];
    end
  end

  assign limit = 32'(s_q.coef) * INV_LIMIT_SCALE;
  assign acc_sum = {1'b0, s_q.acc} + 33'(rate);
  assign inv_done = s_q.acc >= limit;
  assign dly_done = s_q.trip_cnt >= s_q.trip_dly;

  assign blocked_now = |block_in;
  assign above_pu = quantity > s_q.pickup_val;
  assign below_do =
    24'(quantity) * PCT_SCALE < 24'(s_q.pickup_val) * 24'(s_q.dropout);

  // ==========================================================
  // Helper decode
  // Named terms keep the phase and timer logic readable
  logic pu_done;
  logic do_done;
  logic timing_on;
  logic integ_on;
  logic trip_ok;

  assign pu_done = s_q.pu_cnt >= s_q.pu_dly;

  assign do_done = s_q.do_cnt >= s_q.do_dly;

  // trip timer and accumulator run only in pickup with the fault present
  // A dip parks the phase in drop-out, where they only hold while the drop-out timer runs.
  assign timing_on = s_q.phase == PH_PICKUP && s_q.fault;

  // integration waits for the pickup phase, after the pickup delay
  // Frozen once tripped so the accumulator reads back the
  // level reached at the moment of operation.
  assign integ_on = timing_on && s_q.tick && s_q.inv_en &&
    !s_q.trip && !below_do;

  assign trip_ok = dly_done && (!s_q.inv_en || inv_done);

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.blocked = blocked_now;

    // sample tick divider
    // Free running from reset: the first delay tick may come
    // early by up to one tick, a limit of any sampled timer.
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == TICK_LAST) begin
      s_d.tick_cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 1'b1;
    end

    if (s_q.fault) begin
      s_d.fault = !below_do;
    end else begin
      s_d.fault = above_pu;
    end

    // Pickup sequence
    if (blocked_now) begin
      s_d.phase = PH_IDLE;
      s_d.pu_cnt = '0;
      s_d.do_cnt = '0;
    end else begin
      case (s_q.phase)
        PH_IDLE: begin
          s_d.pu_cnt = '0;
          if (s_q.fault) begin
            s_d.phase = PH_CONFIRM;
          end
        end
        PH_CONFIRM: begin
          if (!s_q.fault) begin
            s_d.phase = PH_IDLE;
          end else if (pu_done) begin
            s_d.phase = PH_PICKUP;
          end else if (s_q.tick) begin
            s_d.pu_cnt = s_q.pu_cnt + 1'b1;
          end
        end
        PH_PICKUP: begin
          s_d.do_cnt = '0;
          if (!s_q.fault) begin
            if (s_q.trip) begin
              s_d.phase = PH_IDLE;
            end else begin
              s_d.phase = PH_DROP;
            end
          end
        end
        PH_DROP: begin
          if (s_q.fault) begin
            s_d.phase = PH_PICKUP;
          end else if (do_done) begin
            s_d.phase = PH_IDLE;
          end else if (s_q.tick) begin
            s_d.do_cnt = s_q.do_cnt + 1'b1;
          end
        end
        default: begin
          s_d.phase = PH_IDLE;
        end
      endcase
    end

    // Trip timing
    if (s_d.phase == PH_IDLE || s_d.phase == PH_CONFIRM) begin
      // pickup low clears timer and trip
      s_d.trip_cnt = '0;
      s_d.acc = '0;
      s_d.trip = 1'b0;
    end else if (timing_on) begin
      if (s_q.tick && s_q.trip_cnt != TRIP_CNT_MAX) begin
        s_d.trip_cnt = s_q.trip_cnt + 1'b1;
      end
      // integrate weighted fractions
      // Saturates rather than wraps, so a huge rate cannot
      // roll the sum back below the limit.
      if (integ_on) begin
        s_d.acc = acc_sum[32] ? 32'hffffffff : acc_sum[31:0];
      end
      if (trip_ok) begin
        s_d.trip = 1'b1;
      end
    end

    // ========================================================
    // Register writes
    // New settings apply at once, also in mid-fault; a lower
    // delay can therefore end a running delay on the next clk.
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: begin
          s_d.inv_en = reg_wdata[CTRL_INV_BIT];
          s_d.curve =
            ptl_curve_type'(reg_wdata[CTRL_CURVE_LSB +: 4]);
        end
        REG_PICKUP: s_d.pickup_val = reg_wdata[15:0];
        REG_DROPOUT: s_d.dropout = reg_wdata[7:0];
        REG_PU_DLY: s_d.pu_dly = reg_wdata[15:0];
        REG_DO_DLY: s_d.do_dly = reg_wdata[15:0];
        REG_TRIP_DLY: s_d.trip_dly = reg_wdata[15:0];
        REG_COEF: s_d.coef = reg_wdata[15:0];
        default: begin
          if (reg_addr[7:5] == UTAB_SEL_MSB) begin
            s_d.utab[reg_addr[4:0]] = reg_wdata[15:0];
          end
        end
      endcase
    end

    // Register reads, data valid in the following cycle only
    s_d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: begin
          s_d.rdata[CTRL_INV_BIT] = s_q.inv_en;
          s_d.rdata[CTRL_CURVE_LSB +: 4] = s_q.curve;
        end
        REG_PICKUP: s_d.rdata[15:0] = s_q.pickup_val;
        REG_DROPOUT: s_d.rdata[7:0] = s_q.dropout;
        REG_PU_DLY: s_d.rdata[15:0] = s_q.pu_dly;
        REG_DO_DLY: s_d.rdata[15:0] = s_q.do_dly;
        REG_TRIP_DLY: s_d.rdata[15:0] = s_q.trip_dly;
        REG_COEF: s_d.rdata[15:0] = s_q.coef;
        REG_STATUS: begin
          s_d.rdata[0] = s_q.fault;
          s_d.rdata[1] = s_q.phase[1];
          s_d.rdata[2] = s_q.trip;
          s_d.rdata[3] = s_q.blocked;
          s_d.rdata[5:4] = s_q.phase;
          s_d.rdata[10:8] = bp_idx;
        end
        REG_ACCUM: s_d.rdata = s_q.acc;
        default: begin
          if (reg_addr[7:5] == UTAB_SEL_MSB) begin
            s_d.rdata[15:0] = s_q.utab[reg_addr[4:0]];
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  // Everything not named below clears, user tables included
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.phase <= PH_IDLE;
      s_q.curve <= CRV_IEC_NORMAL;
      s_q.pickup_val <= RST_PICKUP;
      s_q.dropout <= RST_DROPOUT;
      s_q.pu_dly <= RST_PU_DLY;
      s_q.do_dly <= RST_DO_DLY;
      s_q.trip_dly <= RST_TRIP_DLY;
      s_q.coef <= RST_COEF;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  // pickup low while blocked
  assign pickup = s_q.phase[1];
  assign trip = s_q.trip;
  assign pickup_blocked = s_q.blocked;
  assign reg_rdata = s_q.rdata;

endmodule

// ---- dv/ptl_checker.sv ----
// Port-level assertions for the protection pickup/trip block
`timescale 1ns/1ps
module ptl_checker #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ptl_pkg::VAL_W-1:0] quantity,
  input wire logic [ptl_pkg::BLOCK_W-1:0] block_in,
  input wire logic [ptl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ptl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ptl_pkg::DATA_W-1:0] reg_rdata,
  input wire logic pickup,
  input wire logic trip,
  input wire logic pickup_blocked
);
  import ptl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // Sequences
  sequence blk_on_s;
    |block_in;
  endsequence
  sequence blk_release_s;
    (|block_in) ##1 !(|block_in);
  endsequence
  // ==========================================================
  // Assertions
  any_block_a: assert property (blk_on_s |=> !pickup && !trip)
    else $error("pickup or trip high after block");
  blk_status_a: assert property (blk_on_s |=> pickup_blocked)
    else $error("pickup_blocked missing after block");
  pickup_rise_a: assert property ($rose(pickup) |-> !pickup_blocked)
    else $error("pickup rose while blocked");
  trip_pickup_a: assert property (trip |-> pickup)
    else $error("trip high without pickup");
  trip_rise_a: assert property ($rose(trip) |->
    !pickup_blocked && $past(pickup))
    else $error("trip rose without prior pickup");
  pickup_first_a: assert property ($rose(pickup) |-> !trip)
    else $error("trip high when pickup just rose");
  trip_fall_a: assert property ($fell(trip) |-> !pickup)
    else $error("trip fell while pickup stayed");
  blk_restart_a: assert property (blk_release_s |->
    !pickup && !trip ##1 !trip)
    else $error("no restart after block release");
endmodule

bind ptl_pickup_trip ptl_checker #(.TICK_CYCLES(TICK_CYCLES)) u_ptl_checker (
  .clk(clk), .srst(srst), .quantity(quantity), .block_in(block_in),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pickup(pickup), .trip(trip),
  .pickup_blocked(pickup_blocked));

// ---- dv/ptl_field.sv ----
// Measurement front end and breaker relay model
`timescale 1ns/1ps
module ptl_field (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ptl_pkg::VAL_W-1:0] level,
  input wire logic trip,
  output logic [ptl_pkg::VAL_W-1:0] quantity,
  output logic breaker_open
);
  import ptl_pkg::*;
  // One sample of latency, like a real converter
  always_ff @(posedge clk) begin
    quantity <= level;
    if (srst) begin
      breaker_open <= 1'b0;
    end else if (trip) begin
      breaker_open <= 1'b1;
    end
  end
endmodule

// ---- dv/test_protection_pickup_trip.sv ----
// Self-checking bench for the protection pickup/trip block
`timescale 1ns/1ps
module test_protection_pickup_trip;
  import ptl_pkg::*;
  localparam int TC = 10;
  typedef struct {
    logic [7:0] addr;
    logic [31:0] val;
  } ptl_row_type;
  logic clk, srst, reg_wr, reg_rd, pickup, trip, pickup_blocked, brk;
  logic [VAL_W-1:0] level, quantity;
  logic [BLOCK_W-1:0] block_in;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
  int n_mismatch, num_checks, t1, t2, t3;
  ptl_row_type rows [8] = '{'{REG_CTRL, 32'h0}, '{REG_PICKUP, 32'h400},
    '{REG_DROPOUT, 32'h5f}, '{REG_PU_DLY, 32'h5}, '{REG_DO_DLY, 32'h0},
    '{REG_TRIP_DLY, 32'h64}, '{REG_COEF, 32'h64}, '{8'h10, 32'h0}};
  ptl_pickup_trip #(.TICK_CYCLES(TC)) u_ptl_pickup_trip (
    .clk(clk), .srst(srst), .quantity(quantity), .block_in(block_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pickup(pickup), .trip(trip),
    .pickup_blocked(pickup_blocked));
  ptl_field u_ptl_field (.clk(clk), .srst(srst), .level(level),
    .trip(trip), .quantity(quantity), .breaker_open(brk));
  // ==========================================================
  // Tasks: drive on the rising edge, sample on the falling one
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic drive(input logic [15:0] q, input logic [3:0] b);
    @(posedge clk);
    level <= q;
    block_in <= b;
  endtask
  task automatic skip(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Bounded wait; a timeout leaves n at the limit
  task automatic wait_sig(input bit sel, input int lim, output int n);
    n = 0;
    while ((sel ? trip : pickup) !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  // Applies a fault and returns the cycles until trip
  task automatic run(input logic [15:0] q, output int n);
    drive(q, 4'h0);
    wait_sig(1'b1, 3000, n);
    drive(16'h0, 4'h0);
    skip(4);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    results();
  end
  initial begin
    srst = 1'b1;
    level = '0;
    block_in = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    skip(1);
    chk("outputs", 32'h0, {pickup, trip, pickup_blocked});
    foreach (rows[i]) begin
      rd(rows[i].addr);
      chk("reset value", rows[i].val, d);
    end
    $display("test registers done");
    wr(REG_PU_DLY, 32'h2);
    wr(REG_TRIP_DLY, 32'h3);
    wr(REG_DO_DLY, 32'h14);
    rd(REG_DO_DLY);
    chk("readback", 32'h14, d);
    drive(16'h400, 4'h0);
    skip(5 * TC);
    chk("pickup at threshold", 32'h0, pickup);
    drive(16'h401, 4'h0);
    wait_sig(1'b0, 4 * TC, t1);
    chk("pickup delay", 32'h1, t1 >= TC && t1 < 4 * TC);
    wait_sig(1'b1, 5 * TC, t2);
    chk("trip delay", 32'h1, t2 >= 2 * TC && t2 < 5 * TC);
    skip(0);
    chk("breaker", 32'h1, brk);
    drive(16'h0, 4'h0);
    skip(4);
    chk("pickup after trip", 32'h0, pickup);
    $display("test definite time done");
    wr(REG_TRIP_DLY, 32'h64);
    drive(16'h500, 4'h0);
    wait_sig(1'b0, 4 * TC, t1);
    drive(16'h0, 4'h0);
    skip(15 * TC);
    chk("pickup in drop-out", 32'h1, pickup);
    skip(8 * TC);
    chk("pickup after drop-out", 32'h0, pickup);
    wr(REG_DO_DLY, 32'h0);
    drive(16'h500, 4'h0);
    wait_sig(1'b0, 4 * TC, t1);
    drive(16'h3f0, 4'h0);
    skip(5 * TC);
    chk("pickup in hysteresis", 32'h1, pickup);
    drive(16'h3c0, 4'h0);
    skip(2 * TC);
    chk("pickup below drop-out", 32'h0, pickup);
    $display("test drop-out done");
    wr(REG_DO_DLY, 32'h14);
    wr(REG_TRIP_DLY, 32'h1e);
    drive(16'h500, 4'h0);
    wait_sig(1'b0, 4 * TC, t1);
    skip(15 * TC);
    drive(16'h0, 4'h0);
    skip(5 * TC);
    drive(16'h500, 4'h0);
    wait_sig(1'b1, 30 * TC, t2);
    chk("trip after dip", 32'h1, t2 < 22 * TC);
    for (int b = 0; b < BLOCK_W; b++) begin
      drive(16'h500, 4'h1 << b);
      skip(1);
      chk("blocked outputs", 32'h1, {pickup, trip, pickup_blocked});
      drive(16'h500, 4'h0);
      wait_sig(1'b0, 4 * TC, t1);
      chk("restart", 32'h1, t1 >= TC && t1 < 4 * TC);
      wait_sig(1'b1, 40 * TC, t2);
      chk("trip re-timed", 32'h1, t2 >= 28 * TC && t2 < 40 * TC);
    end
    drive(16'h0, 4'h0);
    skip(4);
    $display("test blocking done");
    wr(REG_DO_DLY, 32'h0);
    wr(REG_PU_DLY, 32'h0);
    wr(REG_TRIP_DLY, 32'h1);
    wr(REG_COEF, 32'h1);
    for (int j = 0; j < UTAB_N; j++) begin
      wr(REG_UTAB_BASE + 8'(j), 32'h7fff);
    end
    for (int c = 0; c < 12; c++) begin
      wr(REG_CTRL, {27'h0, 4'(c), 1'b1});
      run(16'h5000, t1);
      chk("curve trip", 32'h1, t1 < 70 * TC);
    end
    wr(REG_CTRL, {27'h0, CRV_IEC_EXTREME, 1'b1});
    wr(REG_TRIP_DLY, 32'h28);
    run(16'h5000, t1);
    chk("minimum time", 32'h1, t1 >= 39 * TC && t1 < 45 * TC);
    wr(REG_TRIP_DLY, 32'h1);
    wr(REG_CTRL, {27'h0, CRV_IEC_VERY, 1'b1});
    wr(REG_COEF, 32'ha);
    run(16'h5000, t1);
    run(16'h6400, t2);
    chk("clamp at 20", 32'h1, t2 - t1 <= TC && t1 - t2 <= TC);
    wr(REG_COEF, 32'h14);
    run(16'h5000, t3);
    chk("coefficient", 32'h1, t3 > t1 + 50 * TC);
    $display("test inverse time done");
    results();
  end
endmodule
